//--- core/rcl_ref_ctrl.sv
// Purpose: AXI4-Lite register bank for the reference path and status pin control
// Assumes: one write and one read outstanding at most; pins synchronised inside
// Notes: every output comes from a flip-flop
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module rcl_ref_ctrl import rcl_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // status pin sources and pll status, asynchronous
  input wire logic [NUM_SRC-1:0] status_src,
  input wire logic eeprom_status,
  input wire logic [REG_W-1:0] pll_status,
  // analog controls and status pin
  output rcl_ref_out_t ref_out,
  output logic status_pin
);
  rcl_state_t st;
  rcl_state_t next_st;
  logic [NUM_SRC-1:0] src_s;
  logic eeprom_s;
  logic [REG_W-1:0] pll_s;

  // one wide synchroniser keeps every pin on the same latency, so pin and readback checks line up
  rcl_sync #(.W(NUM_SRC + 1 + REG_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({status_src, eeprom_status, pll_status}),
    .settled({src_s, eeprom_s, pll_s})
  );

  always_comb begin
    next_st = st;
    // write address and data taken in either order
    if (s_axi_awvalid && st.aw_rdy) begin
      next_st.aw_have = 1'b1;
      next_st.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.w_rdy) begin
      next_st.w_have = 1'b1;
      next_st.wdata = s_axi_wdata[7:0];
      next_st.wlane = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_have && st.w_have && !st.bvalid) begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      case (st.waddr)
        ADR_STATUS_SEL: begin
          if (st.wlane) begin
            next_st.sel_reg = st.wdata;
          end
        end
        // bits [2:1] stored as written; software keeps them clear in differential mode
        ADR_REF_CTRL: begin
          if (st.wlane) begin
            next_st.ctl_reg = st.wdata;
          end
        end
        // readback register is read-only; writes are accepted and dropped
        ADR_PLL_READBACK: next_st.bresp = RESP_OKAY;
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end
    next_st.aw_rdy = !next_st.aw_have && !next_st.bvalid;
    next_st.w_rdy = !next_st.w_have && !next_st.bvalid;
    // read channel
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.ar_rdy) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      case (s_axi_araddr)
        ADR_STATUS_SEL: next_st.rdata = {24'h00_0000, st.sel_reg};
        ADR_REF_CTRL: next_st.rdata = {24'h00_0000, st.ctl_reg};
        ADR_PLL_READBACK: next_st.rdata = {24'h00_0000, st.readback};
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_st.ar_rdy = !next_st.rvalid;
    // frozen readback keeps its last capture for software
    if (!st.ctl_reg[BIT_READBACK_OFF]) begin
      next_st.readback = pll_s;
    end
    if (st.ctl_reg[BIT_EEPROM_PIN]) begin
      next_st.status_pin = eeprom_s;
    end else begin
      next_st.status_pin = src_s[st.sel_reg[SEL_LSB +: SEL_W]];
    end
    next_st.diff_mode = st.ctl_reg[BIT_DIFF_MODE];
    next_st.crystal_amp_enable = st.ctl_reg[BIT_CRYSTAL];
    next_st.doubler_enable = st.ctl_reg[BIT_DOUBLER];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.aw_rdy <= 1'b1;
      st.w_rdy <= 1'b1;
      st.ar_rdy <= 1'b1;
      st.sel_reg <= RST_STATUS_SEL;
      st.ctl_reg <= RST_REF_CTRL;
      st.readback <= RST_READBACK;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.aw_rdy;
  assign s_axi_wready = st.w_rdy;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.ar_rdy;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;
  assign status_pin = st.status_pin;
  assign ref_out.diff_mode = st.diff_mode;
  assign ref_out.crystal_amp_enable = st.crystal_amp_enable;
  assign ref_out.doubler_enable = st.doubler_enable;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_override_held;
    st.ctl_reg[BIT_EEPROM_PIN] ##1 st.ctl_reg[BIT_EEPROM_PIN];
  endsequence
  sequence s_freeze_held;
    st.ctl_reg[BIT_READBACK_OFF] [*2];
  endsequence

  a_eeprom_on_pin: assert property (s_override_held |-> status_pin == $past(eeprom_s))
    else $error("status pin not carrying eeprom status under override");
  a_selected_on_pin: assert property (!st.ctl_reg[BIT_EEPROM_PIN] |=>
    status_pin == $past(src_s[st.sel_reg[SEL_LSB +: SEL_W]]))
    else $error("status pin not following selected source");
  a_crystal_follow: assert property (ref_out.crystal_amp_enable == $past(st.ctl_reg[BIT_CRYSTAL]))
    else $error("crystal enable does not track its bit");
  a_doubler_follow: assert property (st.ctl_reg[BIT_DOUBLER] [*2] |-> ref_out.doubler_enable)
    else $error("doubler not enabled while bit set");
  a_readback_frozen: assert property (s_freeze_held |-> $stable(st.readback))
    else $error("readback changed while refresh disabled");
  a_ctrl_reset_zero: assert property ($rose(aresetn) |-> st.ctl_reg == RST_REF_CTRL)
    else $error("control register not zero after reset");
  a_diff_mode_set: assert property (st.ctl_reg[BIT_DIFF_MODE] [*2] |-> ref_out.diff_mode)
    else $error("differential mode not applied");
  a_mode_default: assert property ($rose(aresetn) ##1 !st.ctl_reg[BIT_DIFF_MODE] |-> !ref_out.diff_mode)
    else $error("reference not single-ended after reset");
  a_readback_read: assert property (s_axi_arvalid && st.ar_rdy && s_axi_araddr == ADR_PLL_READBACK
    && st.ctl_reg[BIT_READBACK_OFF] |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(st.readback))
    else $error("read of frozen readback returned wrong value");
  a_readback_refresh: assert property (!st.ctl_reg[BIT_READBACK_OFF] |=> st.readback == $past(pll_s))
    else $error("readback not refreshed while enabled");

  a_doubler_off: assert property (!st.ctl_reg[BIT_DOUBLER] [*2] |-> !ref_out.doubler_enable)
    else $error("doubler enabled while bit clear");
  a_single_ended: assert property (!st.ctl_reg[BIT_DIFF_MODE] [*2] |-> !ref_out.diff_mode)
    else $error("differential mode while bit clear");
  a_pins_after_reset: assert property ($rose(aresetn) |-> !status_pin && ref_out == '0)
    else $error("outputs not at defaults after reset");
  a_ready_after_reset: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_wready && s_axi_arready)
    else $error("bus not ready after reset");

  // write path in steps: both halves taken, then the commit and the answer on the same edge
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ctrl_commit;
    st.aw_have && st.w_have && !st.bvalid && st.waddr == ADR_REF_CTRL && st.wlane;
  endsequence

  a_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid)
    else $error("write response not two edges after joint take");
  a_ctrl_write_lands: assert property (s_ctrl_commit |=> st.ctl_reg == $past(st.wdata))
    else $error("control register did not take written byte");
  a_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  // a stalled master must see the same answer until it takes it
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one edge after address taken");
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read data bits not zero");
endmodule // rcl_ref_ctrl
`default_nettype wire

//--- core/rcl_pkg.sv
// Purpose: shared constants and types for the reference-control register bank
// Assumes: 32-bit AXI4-Lite, 12-bit byte address, registers at four times their index
// Notes: register width is 8 bits, upper bus bits read as zero
package rcl_pkg;
  localparam int ADDR_W = 12;
  localparam int REG_W = 8;
  // register indices; byte address is index times four
  localparam logic [9:0] IDX_STATUS_SEL = 10'h017;
  localparam logic [9:0] IDX_REF_CTRL = 10'h01C;
  localparam logic [9:0] IDX_PLL_READBACK = 10'h01F;
  localparam logic [11:0] ADR_STATUS_SEL = {IDX_STATUS_SEL, 2'b00};
  localparam logic [11:0] ADR_REF_CTRL = {IDX_REF_CTRL, 2'b00};
  localparam logic [11:0] ADR_PLL_READBACK = {IDX_PLL_READBACK, 2'b00};
  // reference control fields
  localparam int BIT_DIFF_MODE = 0;
  localparam int BIT_READBACK_OFF = 4;
  localparam int BIT_DOUBLER = 5;
  localparam int BIT_CRYSTAL = 6;
  localparam int BIT_EEPROM_PIN = 7;
  // status select field [7:2]
  localparam int SEL_LSB = 2;
  localparam int SEL_W = 6;
  localparam int NUM_SRC = 64;
  // reset values
  localparam logic [7:0] RST_STATUS_SEL = 8'h00;
  localparam logic [7:0] RST_REF_CTRL = 8'h00;
  localparam logic [7:0] RST_READBACK = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic aw_have;
    logic w_have;
    logic [11:0] waddr;
    logic [7:0] wdata;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] sel_reg;
    logic [7:0] ctl_reg;
    logic [7:0] readback;
    logic status_pin;
    logic diff_mode;
    logic crystal_amp_enable;
    logic doubler_enable;
  } rcl_state_t;

  typedef struct packed {
    logic diff_mode;
    logic crystal_amp_enable;
    logic doubler_enable;
  } rcl_ref_out_t;
endpackage

//--- core/rcl_sync.sv
// Purpose: three-stage synchroniser for a vector of pin inputs
// Assumes: inputs asynchronous to aclk
// Notes: a bit changes only once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module rcl_sync import rcl_pkg::*; #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins and settled value
  input wire logic [W-1:0] pin,
  output logic [W-1:0] settled
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1[i] <= 1'b0;
          s2[i] <= 1'b0;
          s3[i] <= 1'b0;
          settled[i] <= 1'b0;
        end else begin
          s1[i] <= pin[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          // s1 feeds only s2; filter looks at s2 and s3
          if (s2[i] == s3[i]) begin
            settled[i] <= s3[i];
          end
        end
      end
    end
  endgenerate
endmodule // rcl_sync
`default_nettype wire

//--- tb/rcl_ref_ctrl_tb_top.sv
// Purpose: self-checking bench for the reference-control register bank
// Assumes: write commits two edges after a joint take, pins reach the block four edges late
// Notes: bench drives every port itself; expectations come from plain integer bookkeeping
`timescale 1ns/100ps
`default_nettype none
module rcl_ref_ctrl_tb_top import rcl_pkg::*; ;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, eeprom_status = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [63:0] status_src = 64'h0;
  logic [7:0] pll_status = 8'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, status_pin;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  rcl_ref_out_t ref_out;
  int num_errors = 0, total_checks = 0, v, k, r;
  // register model kept by the bus tasks; readback follows the pin unless frozen
  int mdl_sel = 0, mdl_ctl = 0, mdl_rb = 0;

  rcl_ref_ctrl DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .status_src, .eeprom_status, .pll_status, .ref_out, .status_pin);

  initial begin
    forever #2 aclk = ~aclk;
  end

  task automatic end_of_test();
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic int mdl_rd(input logic [11:0] a);
    if (a == ADR_STATUS_SEL) return mdl_sel;
    if (a == ADR_REF_CTRL) return mdl_ctl;
    if (a == ADR_PLL_READBACK) return mdl_ctl[4] ? mdl_rb : int'(pll_status);
    return 0;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic rst();
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    mdl_sel = RST_STATUS_SEL;
    mdl_ctl = RST_REF_CTRL;
    mdl_rb = RST_READBACK;
  endtask

  // ready is registered, so its level at the falling edge is what the next rising edge sees
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    int n;
    tb = 1'h0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'($urandom), d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!tb && n < 100) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      if (tb) chk(s_axi_bresp, er);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) s_axi_bready <= 1'h0;
      n++;
    end
    if (!tb) chk(32'h0, 32'h1);
    if (tb && er == RESP_OKAY && s_axi_wstrb[0]) begin
      if (a == ADR_STATUS_SEL) mdl_sel = d;
      if (a == ADR_REF_CTRL && d[4] && !mdl_ctl[4]) mdl_rb = pll_status;
      if (a == ADR_REF_CTRL) mdl_ctl = d;
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    int n;
    tr = 1'h0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!tr && n < 100) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      if (tr) chk(s_axi_rdata, ed);
      if (tr) chk(s_axi_rdata, mdl_rd(a));
      if (tr) chk(s_axi_rresp, er);
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) s_axi_rready <= 1'h0;
      n++;
    end
    if (!tr) chk(32'h0, 32'h1);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'hc5d4));
    rst();
    chk(ref_out, 3'h0);
    rd(ADR_REF_CTRL, 32'h0, RESP_OKAY);
    rd(ADR_STATUS_SEL, 32'h0, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      v = $urandom & 32'h6f;
      v[0] = i[0];
      if (v[0]) v[2:1] = 2'h0;
      wr(ADR_REF_CTRL, v[7:0], RESP_OKAY);
      rd(ADR_REF_CTRL, v, RESP_OKAY);
      cyc(2);
      chk(ref_out, {v[0], v[6], v[5]});
    end
    for (int i = 0; i < 4; i++) begin
      k = $urandom % 64;
      @(posedge aclk);
      status_src <= {$urandom, $urandom};
      wr(ADR_STATUS_SEL, {k[5:0], i[1:0]}, RESP_OKAY);
      rd(ADR_STATUS_SEL, {k[5:0], i[1:0]}, RESP_OKAY);
      cyc(8);
      chk(status_pin, status_src[k]);
    end
    wr(ADR_REF_CTRL, 8'h80, RESP_OKAY);
    for (int e = 0; e < 2; e++) begin
      @(posedge aclk);
      eeprom_status <= e[0];
      status_src <= {64{~e[0]}};
      cyc(8);
      chk(status_pin, e[0]);
    end
    // refresh on, then frozen, then a write attempt on the read-only copy
    r = $urandom & 32'hff;
    wr(ADR_REF_CTRL, 8'h00, RESP_OKAY);
    @(posedge aclk);
    pll_status <= r[7:0];
    cyc(8);
    rd(ADR_PLL_READBACK, r, RESP_OKAY);
    wr(ADR_REF_CTRL, 8'h10, RESP_OKAY);
    @(posedge aclk);
    pll_status <= ~r[7:0];
    cyc(8);
    rd(ADR_PLL_READBACK, r, RESP_OKAY);
    wr(ADR_PLL_READBACK, 8'ha5, RESP_OKAY);
    rd(ADR_PLL_READBACK, r, RESP_OKAY);
    wr(ADR_REF_CTRL, 8'h00, RESP_OKAY);
    cyc(8);
    rd(ADR_PLL_READBACK, ~r & 32'hff, RESP_OKAY);
    // a write with its low lane off is answered but leaves the register alone
    @(posedge aclk);
    s_axi_wstrb <= 4'h0;
    wr(ADR_REF_CTRL, 8'h61, RESP_OKAY);
    rd(ADR_REF_CTRL, 32'h0, RESP_OKAY);
    @(posedge aclk);
    s_axi_wstrb <= 4'h1;
    wr(12'h100, 8'h5a, RESP_SLVERR);
    rd(12'h100, 32'h0, RESP_SLVERR);
    // second reset in mid-run must bring back the defaults
    wr(ADR_REF_CTRL, 8'h61, RESP_OKAY);
    rst();
    chk(ref_out, 3'h0);
    rd(ADR_REF_CTRL, 32'h0, RESP_OKAY);
    end_of_test();
  end
endmodule // rcl_ref_ctrl_tb_top
`default_nettype wire
